//--- src/dio_pkg.sv
// constants shared by the ddr i/o register block
package dio_pkg;
    // static load values, fixed when the design is built
    localparam logic ASYNC_LOAD_VALUE = 1'h0;
    localparam logic SYNC_LOAD_VALUE = 1'h0;
    // output cell variants
    localparam logic CELL_PLAIN = 1'h0;
    localparam logic CELL_INVERT = 1'h1;
    // single rate select encoding
    localparam logic RATE_DOUBLE = 1'h0;
    localparam logic RATE_SINGLE = 1'h1;
    // capture pair buffer
    localparam int PAIR_W = 2;
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    // capture pair field positions
    localparam int PAIR_RISE = 1;
    localparam int PAIR_FALL = 0;
endpackage : dio_pkg

//--- src/dio_stream_if.sv
// valid/ready carrier for captured rise/fall pairs
`timescale 1ns/1ps
interface dio_stream_if;
    logic [dio_pkg::PAIR_W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : dio_stream_if

//--- src/dio_pair_buf.sv
// two-entry buffer for captured pairs
`timescale 1ns/1ps
module dio_pair_buf (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // streams
    dio_stream_if.snk in_s,
    dio_stream_if.src out_s
);
    logic [dio_pkg::PAIR_W-1:0] mem [2];
    logic [dio_pkg::PAIR_W-1:0] next_mem [2];
    logic [1:0] count;
    logic [1:0] next_count;
    logic rd;
    logic next_rd;
    logic wr;
    logic next_wr;
    logic push;
    logic pop;

    // handshakes; ready is honest full
    assign push = in_s.valid && (count != dio_pkg::BUF_DEPTH);
    assign pop = (count != dio_pkg::BUF_EMPTY) && out_s.ready;
    assign in_s.ready = (count != dio_pkg::BUF_DEPTH);
    assign out_s.valid = (count != dio_pkg::BUF_EMPTY);
    assign out_s.data = mem[rd];

    // next pointers, count and storage
    always_comb begin
        next_mem = mem;
        next_wr = wr;
        next_rd = rd;
        next_count = count;
        if (push) begin
            next_mem[wr] = in_s.data;
            next_wr = ~wr;
        end
        if (pop) begin
            next_rd = ~rd;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    // register state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem[0] <= 2'h0;
            mem[1] <= 2'h0;
            wr <= 1'h0;
            rd <= 1'h0;
            count <= 2'h0;
        end else begin
            mem <= next_mem;
            wr <= next_wr;
            rd <= next_rd;
            count <= next_count;
        end
    end

    // a stalled head word stays put
    buf_head_hold_a: assert property (@(posedge mclk) disable iff (rst)
        out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data))
        else $error("buffer head changed while stalled");
    buf_full_a: assert property (@(posedge mclk) disable iff (rst)
        count == dio_pkg::BUF_DEPTH |-> !in_s.ready)
        else $error("buffer ready while full");
endmodule : dio_pair_buf

//--- src/dio_out_cell.sv
// double-rate output cell with optional inverting storage
`timescale 1ns/1ps
module dio_out_cell #(
    parameter logic INVERT = dio_pkg::CELL_PLAIN
) (
    // clock and loads
    input wire logic mclk,
    input wire logic rst,
    input wire logic async_load_n,
    input wire logic sync_load_n,
    input wire logic cell_en,
    // data and mode
    input wire logic rise_edge_data_in,
    input wire logic fall_edge_data_in,
    input wire logic single_rate_select,
    // pad side
    output logic pad_q
);
    logic qr;
    logic qf;
    logic next_qr;
    logic next_qf;

    // next register values, loads before data
    always_comb begin
        next_qr = qr;
        next_qf = qf;
        if (cell_en) begin // [R4]
            if (!sync_load_n) begin // [R10] [R19]
                next_qr = dio_pkg::SYNC_LOAD_VALUE;
                next_qf = dio_pkg::SYNC_LOAD_VALUE;
            end else begin
                next_qr = rise_edge_data_in ^ INVERT; // [R7] [R12]
                next_qf = fall_edge_data_in ^ INVERT; // [R7] [R12]
            end
        end
    end

    // async load forces both registers
    always_ff @(posedge mclk or posedge rst or negedge async_load_n) begin
        if (rst || !async_load_n) begin // [R9] [R19]
            qr <= ~dio_pkg::ASYNC_LOAD_VALUE;
            qf <= ~dio_pkg::ASYNC_LOAD_VALUE;
        end else begin
            qr <= next_qr;
            qf <= next_qf;
        end
    end

    // pad follows clock phase, or rise only in single rate
    assign pad_q = (single_rate_select || mclk) ? qr : qf; // [R8] [R13] [R14]

    sequence out_take_s;
        cell_en && sync_load_n;
    endsequence

    out_capture_a: assert property (@(posedge mclk)
        disable iff (rst || !async_load_n)
        out_take_s |=> qr == ($past(rise_edge_data_in) ^ INVERT)
            && qf == ($past(fall_edge_data_in) ^ INVERT)) // [R7]
        else $error("output cell capture wrong");
    out_sync_a: assert property (@(posedge mclk)
        disable iff (rst || !async_load_n)
        cell_en && !sync_load_n |=> qr == dio_pkg::SYNC_LOAD_VALUE
            && qf == dio_pkg::SYNC_LOAD_VALUE) // [R10]
        else $error("output cell sync load wrong");
    out_async_a: assert property (@(posedge mclk) disable iff (rst)
        !async_load_n |-> pad_q == ~dio_pkg::ASYNC_LOAD_VALUE) // [R9]
        else $error("output pad not forced by async load");
    // sampled just before the rise, so the clock is still in its low phase
    out_low_phase_a: assert property (@(posedge mclk) disable iff (rst)
        pad_q == (single_rate_select ? qr : qf)) // [R8]
        else $error("output pad wrong in low phase");
endmodule : dio_out_cell

//--- src/dio_top.sv
// ddr input/output register cells with pad buffers
// Operation
// [R1] async load low forces both input captures to inverse of async value
// [R2] enabled rising edge with sync load low loads sync value
// [R3] fall edge holds pad; enabled rise shows pad and held value
// [R4] enable low at rising edge keeps both stored values
// [R5] async and sync load values are build-time constants
// [R6] input cell data pin connects straight to a pad
// [R7] enabled rise without sync load captures rise and fall data
// [R8] output pad shows rise register when clock high, fall when low
// [R9] async load low forces output registers and pad to inverse value
// [R10] enabled rise with sync load low loads sync value in output
// [R11] output cell drives a pad directly
// [R12] inverting variant stores complement of both data inputs
// [R13] select 0 means double rate, 1 means single rate
// [R14] single rate drives pad from rise register all period
// [R15] tristate driver drives data when enabled, else releases pad
// [R16] differential driver drives true pad with data, comp with inverse
// [R17] bidirectional buffer drives when enabled, else passes pad level in
// [R18] differential receiver decodes opposite pads, equal pads are unknown
// [R19] async load beats sync load, sync load beats data capture
`timescale 1ns/1ps
module dio_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // cell controls
    input wire logic async_load_n,
    input wire logic sync_load_n,
    input wire logic capture_en,
    input wire logic drive_en,
    input wire logic single_rate_select,
    // input cell pad and captured stream
    input wire logic pad_ddr_in,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rise_capture_out,
    output logic fall_capture_out,
    // output cells
    input wire logic rise_edge_data_in,
    input wire logic fall_edge_data_in,
    input wire logic rise_edge_data_in_inv,
    input wire logic fall_edge_data_in_inv,
    output logic pad_ddr_out,
    output logic pad_ddr_out_inv,
    // tristate pad driver
    input wire logic tri_data,
    input wire logic tri_en,
    output logic tri_pad_o,
    output logic tri_pad_oe,
    // differential pad driver
    input wire logic diff_data,
    output logic pad_true,
    output logic pad_comp,
    // bidirectional pad buffer
    input wire logic bidir_data,
    input wire logic bidir_en,
    input wire logic bidir_pad_i,
    output logic bidir_pad_o,
    output logic bidir_pad_oe,
    output logic bidir_y,
    // differential pad receiver
    input wire logic rx_pad_true,
    input wire logic rx_pad_comp,
    output logic diff_rx_y,
    output logic diff_rx_known
);
    logic cap_r;
    logic cap_f;
    logic held;
    logic next_cap_r;
    logic next_cap_f;
    logic eff_en;
    logic bidir_s1;
    logic bidir_s2;
    logic rxp_s1;
    logic rxp_s2;
    logic rxn_s1;
    logic rxn_s2;
    logic next_tri_o;
    logic next_tri_oe;
    logic next_true;
    logic next_comp;
    logic next_bidir_o;
    logic next_bidir_oe;
    logic next_bidir_y;
    logic next_rx_y;
    logic next_rx_known;

    dio_stream_if cap_if ();
    dio_stream_if fab_if ();

    ////////////////////////////////////////////////////////////////////////
    // double-rate input cell

    // enable gated by buffer room so a stall loses no pair
    assign eff_en = capture_en && cap_if.ready;

    // next capture values, load before data
    always_comb begin
        next_cap_r = cap_r;
        next_cap_f = cap_f;
        if (eff_en) begin // [R4]
            if (!sync_load_n) begin // [R2] [R19]
                next_cap_r = dio_pkg::SYNC_LOAD_VALUE;
                next_cap_f = dio_pkg::SYNC_LOAD_VALUE;
            end else begin
                next_cap_r = pad_ddr_in; // [R3] [R6]
                next_cap_f = held; // [R3]
            end
        end
    end

    // rising-edge capture registers
    always_ff @(posedge mclk or posedge rst or negedge async_load_n) begin
        if (rst || !async_load_n) begin // [R1] [R19]
            cap_r <= ~dio_pkg::ASYNC_LOAD_VALUE;
            cap_f <= ~dio_pkg::ASYNC_LOAD_VALUE;
        end else begin
            cap_r <= next_cap_r;
            cap_f <= next_cap_f;
        end
    end

    // falling-edge hold of the pad level
    always_ff @(negedge mclk or posedge rst or negedge async_load_n) begin
        if (rst || !async_load_n) begin // [R1]
            held <= ~dio_pkg::ASYNC_LOAD_VALUE;
        end else begin
            held <= pad_ddr_in; // [R3]
        end
    end

    // every taken capture is pushed as one pair; none while async load holds
    assign cap_if.valid = eff_en && async_load_n;
    assign cap_if.data[dio_pkg::PAIR_RISE] = next_cap_r;
    assign cap_if.data[dio_pkg::PAIR_FALL] = next_cap_f;
    assign fab_if.ready = rx_ready;
    assign rx_valid = fab_if.valid;

    dio_pair_buf u_buf (
        .mclk (mclk),
        .rst (rst),
        .in_s (cap_if.snk),
        .out_s (fab_if.src)
    );

    // cell outputs straight from the capture registers
    assign rise_capture_out = cap_r;
    assign fall_capture_out = cap_f;

    ////////////////////////////////////////////////////////////////////////
    // double-rate output cells, plain and inverting

    // plain cell always runs double rate
    dio_out_cell #(
        .INVERT (dio_pkg::CELL_PLAIN)
    ) u_out (
        .mclk (mclk),
        .rst (rst),
        .async_load_n (async_load_n),
        .sync_load_n (sync_load_n),
        .cell_en (drive_en),
        .rise_edge_data_in (rise_edge_data_in),
        .fall_edge_data_in (fall_edge_data_in),
        .single_rate_select (dio_pkg::RATE_DOUBLE),
        .pad_q (pad_ddr_out) // [R11]
    );

    // inverting variant with rate select
    dio_out_cell #(
        .INVERT (dio_pkg::CELL_INVERT)
    ) u_out_inv (
        .mclk (mclk),
        .rst (rst),
        .async_load_n (async_load_n),
        .sync_load_n (sync_load_n),
        .cell_en (drive_en),
        .rise_edge_data_in (rise_edge_data_in_inv),
        .fall_edge_data_in (fall_edge_data_in_inv),
        .single_rate_select (single_rate_select), // [R13]
        .pad_q (pad_ddr_out_inv) // [R11]
    );

    ////////////////////////////////////////////////////////////////////////
    // pad buffers

    // pad inputs pass two flops first
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bidir_s1 <= 1'h0;
            bidir_s2 <= 1'h0;
            rxp_s1 <= 1'h0;
            rxp_s2 <= 1'h0;
            rxn_s1 <= 1'h0;
            rxn_s2 <= 1'h0;
        end else begin
            bidir_s1 <= bidir_pad_i;
            bidir_s2 <= bidir_s1;
            rxp_s1 <= rx_pad_true;
            rxp_s2 <= rxp_s1;
            rxn_s1 <= rx_pad_comp;
            rxn_s2 <= rxn_s1;
        end
    end

    // next values for drivers and receivers
    always_comb begin
        next_tri_o = tri_data;
        next_tri_oe = tri_en; // [R15]
        next_true = diff_data; // [R16]
        next_comp = ~diff_data; // [R16]
        next_bidir_o = bidir_data;
        next_bidir_oe = bidir_en; // [R17]
        next_bidir_y = bidir_en ? bidir_data : bidir_s2; // [R17]
        next_rx_known = 1'h0;
        next_rx_y = 1'h0;
        // only opposite levels decode; equal or floating pads stay unknown
        case ({rxp_s2, rxn_s2})
            2'h1: begin
                next_rx_known = 1'h1; // [R18]
                next_rx_y = 1'h0; // [R18]
            end
            2'h2: begin
                next_rx_known = 1'h1; // [R18]
                next_rx_y = 1'h1; // [R18]
            end
            default: begin
                next_rx_known = 1'h0; // [R18]
                next_rx_y = 1'h0;
            end
        endcase
    end

    // register all pad buffer outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tri_pad_o <= 1'h0;
            tri_pad_oe <= 1'h0;
            pad_true <= 1'h0;
            pad_comp <= 1'h1;
            bidir_pad_o <= 1'h0;
            bidir_pad_oe <= 1'h0;
            bidir_y <= 1'h0;
            diff_rx_y <= 1'h0;
            diff_rx_known <= 1'h0;
        end else begin
            tri_pad_o <= next_tri_o;
            tri_pad_oe <= next_tri_oe;
            pad_true <= next_true;
            pad_comp <= next_comp;
            bidir_pad_o <= next_bidir_o;
            bidir_pad_oe <= next_bidir_oe;
            bidir_y <= next_bidir_y;
            diff_rx_y <= next_rx_y;
            diff_rx_known <= next_rx_known;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence in_take_s;
        eff_en && sync_load_n;
    endsequence

    sequence in_load_s;
        eff_en && !sync_load_n;
    endsequence

    in_async_a: assert property (@(posedge mclk) disable iff (rst)
        !async_load_n |-> rise_capture_out == ~dio_pkg::ASYNC_LOAD_VALUE
            && fall_capture_out == ~dio_pkg::ASYNC_LOAD_VALUE) // [R1]
        else $error("input cell not forced by async load");
    in_sync_a: assert property (@(posedge mclk)
        disable iff (rst || !async_load_n)
        in_load_s |=> rise_capture_out == dio_pkg::SYNC_LOAD_VALUE
            && fall_capture_out == dio_pkg::SYNC_LOAD_VALUE) // [R2]
        else $error("input cell sync load wrong");
    in_data_a: assert property (@(posedge mclk)
        disable iff (rst || !async_load_n)
        in_take_s |=> rise_capture_out == $past(pad_ddr_in)
            && fall_capture_out == $past(held)) // [R3]
        else $error("input cell capture wrong");
    in_hold_a: assert property (@(posedge mclk)
        disable iff (rst || !async_load_n)
        !eff_en |=> $stable(rise_capture_out)
            && $stable(fall_capture_out)) // [R4]
        else $error("input cell changed while disabled");
    diff_drv_a: assert property (@(posedge mclk) disable iff (rst)
        ##1 pad_comp == ~pad_true && pad_true == $past(diff_data)) // [R16]
        else $error("differential driver wrong");
    bidir_in_a: assert property (@(posedge mclk) disable iff (rst)
        !bidir_en ##1 !bidir_en |=> !bidir_pad_oe
            ##0 bidir_y == $past(bidir_s2)) // [R17]
        else $error("bidirectional input path wrong");
    tri_drv_a: assert property (@(posedge mclk) disable iff (rst)
        tri_en |=> tri_pad_oe && tri_pad_o == $past(tri_data)) // [R15]
        else $error("tristate driver wrong");
    diff_rx_a: assert property (@(posedge mclk) disable iff (rst)
        rxp_s2 == rxn_s2 |=> !diff_rx_known) // [R18]
        else $error("differential receiver flagged equal pads");
endmodule : dio_top

//--- tb/dio_pad_model.sv
// pad-side model: ddr input pad and bidirectional pad wire
`timescale 1ns/1ps
module dio_pad_model (
    // clock
    input wire logic mclk,
    // ddr input pad pattern
    input wire logic rise_bit,
    input wire logic fall_bit,
    output logic pad_ddr_in,
    // bidirectional pad
    input wire logic bidir_pad_o,
    input wire logic bidir_pad_oe,
    input wire logic ext_en,
    input wire logic ext_v,
    output logic bidir_pad_i
);
    logic last = 1'h0;
    // fall half seen at falling edge, rise half at rising edge
    initial begin
        pad_ddr_in = 1'h0;
        forever begin
            @(posedge mclk);
            #10 pad_ddr_in = fall_bit;
            @(negedge mclk);
            #10 pad_ddr_in = rise_bit;
        end
    end
    // an undriven pad shows the inverse of its last level, never a stale one
    always_ff @(posedge mclk) begin
        last <= bidir_pad_i;
    end
    assign bidir_pad_i = bidir_pad_oe ? bidir_pad_o :
                         (ext_en ? ext_v : ~last);
endmodule : dio_pad_model

//--- tb/testbench.sv
// self-checking bench for the ddr i/o register block
`timescale 1ns/1ps
module testbench;
    logic mclk, rst, async_load_n, sync_load_n, capture_en, drive_en;
    logic single_rate_select, rise_bit, fall_bit, pad_ddr_in;
    logic rx_valid, rx_ready, rise_capture_out, fall_capture_out;
    logic dr, df, dri, dfi, pad_ddr_out, pad_ddr_out_inv;
    logic tri_data, tri_en, tri_pad_o, tri_pad_oe;
    logic diff_data, pad_true, pad_comp, ext_en, ext_v;
    logic bidir_data, bidir_en, bidir_pad_i, bidir_pad_o, bidir_pad_oe;
    logic bidir_y, rx_pad_true, rx_pad_comp, diff_rx_y, diff_rx_known;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // static load values fixed at build time
    localparam logic AV = ~dio_pkg::ASYNC_LOAD_VALUE;
    localparam logic SV = dio_pkg::SYNC_LOAD_VALUE;
    ////////////////////////////////////////
    dio_top dio_top_i (.mclk(mclk), .rst(rst), .async_load_n(async_load_n),
        .sync_load_n(sync_load_n), .capture_en(capture_en),
        .drive_en(drive_en), .single_rate_select(single_rate_select),
        .pad_ddr_in(pad_ddr_in), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rise_capture_out(rise_capture_out),
        .fall_capture_out(fall_capture_out), .rise_edge_data_in(dr),
        .fall_edge_data_in(df), .rise_edge_data_in_inv(dri),
        .fall_edge_data_in_inv(dfi), .pad_ddr_out(pad_ddr_out),
        .pad_ddr_out_inv(pad_ddr_out_inv), .tri_data(tri_data),
        .tri_en(tri_en), .tri_pad_o(tri_pad_o), .tri_pad_oe(tri_pad_oe),
        .diff_data(diff_data), .pad_true(pad_true), .pad_comp(pad_comp),
        .bidir_data(bidir_data), .bidir_en(bidir_en),
        .bidir_pad_i(bidir_pad_i), .bidir_pad_o(bidir_pad_o),
        .bidir_pad_oe(bidir_pad_oe), .bidir_y(bidir_y),
        .rx_pad_true(rx_pad_true), .rx_pad_comp(rx_pad_comp),
        .diff_rx_y(diff_rx_y), .diff_rx_known(diff_rx_known));
    dio_pad_model dio_pad_model_i (.mclk(mclk), .rise_bit(rise_bit),
        .fall_bit(fall_bit), .pad_ddr_in(pad_ddr_in),
        .bidir_pad_o(bidir_pad_o), .bidir_pad_oe(bidir_pad_oe),
        .ext_en(ext_en), .ext_v(ext_v), .bidir_pad_i(bidir_pad_i));
    ////////////////////////////////////////
    // clock and hang guard
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("ERROR cycle_limit expected below 3000 seen %0d", cycles);
            results();
        end
    end
    // single-bit compare
    task automatic chk(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : chk
    // one capture: pad pair, then a single enable cycle
    task automatic in_pair(input logic r, f, en, sl, er, ef);
        @(negedge mclk);
        rise_bit = r;
        fall_bit = f;
        @(negedge mclk);
        capture_en = en;
        sync_load_n = sl;
        @(negedge mclk);
        capture_en = 1'h0;
        sync_load_n = 1'h1;
        chk("rise_capture_out", er, rise_capture_out);
        chk("fall_capture_out", ef, fall_capture_out);
    endtask : in_pair
    // one enabled output cycle, pads checked in both clock phases
    task automatic out_pair(input logic r, f, ri, fi, sel, sl);
        @(negedge mclk);
        dr = r;
        df = f;
        dri = ri;
        dfi = fi;
        single_rate_select = sel;
        sync_load_n = sl;
        drive_en = 1'h1;
        @(posedge mclk);
        #10;
        chk("pad_ddr_out high", sl ? r : SV, pad_ddr_out);
        chk("pad_ddr_out_inv high", sl ? ~ri : SV, pad_ddr_out_inv);
        @(negedge mclk);
        drive_en = 1'h0;
        sync_load_n = 1'h1;
        #10;
        chk("pad_ddr_out low", sl ? f : SV, pad_ddr_out);
        chk("pad_ddr_out_inv low",
            sl ? ((sel === dio_pkg::RATE_SINGLE) ? ~ri : ~fi) : SV,
            pad_ddr_out_inv);
    endtask : out_pair
    // differential receiver decode after sync and register
    task automatic rx_chk(input logic t, c, ey, ek);
        @(negedge mclk);
        rx_pad_true = t;
        rx_pad_comp = c;
        repeat (5) @(negedge mclk);
        chk("diff_rx_y", ey, diff_rx_y);
        chk("diff_rx_known", ek, diff_rx_known);
    endtask : rx_chk
    ////////////////////////////////////////
    // input cell capture, hold and sync load
    task automatic t_capture();
        rx_ready = 1'h1;
        in_pair(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
        in_pair(1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
        in_pair(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
        in_pair(1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1);
        in_pair(1'h1, 1'h1, 1'h1, 1'h0, SV, SV);
        in_pair(1'h1, 1'h1, 1'h0, 1'h0, SV, SV);
        $display("test capture done");
    endtask : t_capture
    // output cells: plain, inverting, single rate, hold, sync load
    task automatic t_output();
        out_pair(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
        out_pair(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
        out_pair(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
        @(negedge mclk);
        dr = 1'h0;
        df = 1'h1;
        @(posedge mclk);
        #10 chk("pad_ddr_out held high", 1'h1, pad_ddr_out);
        @(negedge mclk);
        #10 chk("pad_ddr_out held low", 1'h0, pad_ddr_out);
        out_pair(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        $display("test output done");
    endtask : t_output
    // async load beats everything, takes effect without a clock edge
    task automatic t_async();
        @(negedge mclk);
        async_load_n = 1'h0;
        sync_load_n = 1'h0;
        capture_en = 1'h1;
        drive_en = 1'h1;
        #10 chk("rise_capture_out", AV, rise_capture_out);
        chk("fall_capture_out", AV, fall_capture_out);
        chk("pad_ddr_out", AV, pad_ddr_out);
        chk("pad_ddr_out_inv", AV, pad_ddr_out_inv);
        @(posedge mclk);
        #10 chk("rise_capture_out", AV, rise_capture_out);
        chk("pad_ddr_out", AV, pad_ddr_out);
        @(negedge mclk);
        async_load_n = 1'h1;
        sync_load_n = 1'h1;
        capture_en = 1'h0;
        drive_en = 1'h0;
        $display("test async done");
    endtask : t_async
    // pad buffers
    task automatic t_pads();
        @(negedge mclk);
        tri_data = 1'h1;
        tri_en = 1'h1;
        diff_data = 1'h1;
        bidir_data = 1'h1;
        bidir_en = 1'h1;
        repeat (2) @(negedge mclk);
        chk("tri_pad_o", 1'h1, tri_pad_o);
        chk("tri_pad_oe", 1'h1, tri_pad_oe);
        chk("pad_true", 1'h1, pad_true);
        chk("pad_comp", 1'h0, pad_comp);
        chk("bidir_pad_o", 1'h1, bidir_pad_o);
        chk("bidir_pad_oe", 1'h1, bidir_pad_oe);
        chk("bidir_y", 1'h1, bidir_y);
        tri_en = 1'h0;
        diff_data = 1'h0;
        bidir_en = 1'h0;
        ext_en = 1'h1;
        ext_v = 1'h0;
        repeat (6) @(negedge mclk);
        chk("tri_pad_oe", 1'h0, tri_pad_oe);
        chk("pad_true", 1'h0, pad_true);
        chk("pad_comp", 1'h1, pad_comp);
        chk("bidir_pad_oe", 1'h0, bidir_pad_oe);
        chk("bidir_y", 1'h0, bidir_y);
        rx_chk(1'h0, 1'h1, 1'h0, 1'h1);
        rx_chk(1'h1, 1'h0, 1'h1, 1'h1);
        rx_chk(1'h0, 1'h0, 1'h0, 1'h0);
        rx_chk(1'h1, 1'h1, 1'h0, 1'h0);
        rx_chk(1'hZ, 1'hZ, 1'h0, 1'h0);
        $display("test pads done");
    endtask : t_pads
    // buffer fills with receiver stalled, refuses, then drains
    task automatic t_buffer();
        rx_ready = 1'h0;
        in_pair(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
        chk("rx_valid", 1'h1, rx_valid);
        in_pair(1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
        in_pair(1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
        chk("rx_valid", 1'h1, rx_valid);
        rx_ready = 1'h1;
        repeat (3) @(negedge mclk);
        chk("rx_valid", 1'h0, rx_valid);
        in_pair(1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1);
        $display("test buffer done");
    endtask : t_buffer
    // verdict
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////
    // reset, then each scenario in turn
    initial begin
        {async_load_n, sync_load_n, rx_ready, rst} = 4'hF;
        {capture_en, drive_en, single_rate_select, rise_bit} = 4'h0;
        {fall_bit, dr, df, dri, dfi, tri_data, tri_en} = 7'h00;
        {diff_data, bidir_data, bidir_en, ext_en, ext_v} = 5'h00;
        rx_pad_true = 1'h0;
        rx_pad_comp = 1'h1;
        repeat (6) @(negedge mclk);
        chk("rise_capture_out", AV, rise_capture_out);
        chk("pad_ddr_out", AV, pad_ddr_out);
        chk("rx_valid", 1'h0, rx_valid);
        chk("tri_pad_oe", 1'h0, tri_pad_oe);
        chk("pad_comp", 1'h1, pad_comp);
        chk("bidir_pad_oe", 1'h0, bidir_pad_oe);
        repeat (6) @(negedge mclk);
        rst = 1'h0;
        t_capture();
        t_output();
        t_async();
        t_pads();
        t_buffer();
        results();
    end
endmodule : testbench
